// file: sra_top.sv
// Serial ports and remote alarm relay with APB register access
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module sra_top #(
  parameter int unsigned CLK_HZ = sra_pkg::CLK_HZ
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [31:0]      prdata_o,
  output logic             irq_o,
  input  wire logic [2:0]  rxd_i,
  input  wire logic [2:0]  cts_i,
  output logic [2:0]       txd_o,
  output logic [2:0]       rts_o,
  output logic [2:0]       dtr_o,
  output logic [1:0]       port_one_profile_o,
  input  wire logic        power_switch_on_i,
  output logic             relay_coil_o,
  output logic             contact_no_closed_o,
  output logic             contact_nc_closed_o
);
  import sra_pkg::*;

  if (CLK_HZ / BAUD_TBL[0] > 65535 || CLK_HZ / BAUD_TBL[NBAUD-1] < 4) begin : g_chk
    $error("CLK_HZ outside the range the baud dividers serve");
  end

  typedef struct packed {
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    sra_cfg_s             pend;
    sra_cfg_s             act;
    logic                 urg;
    logic                 sil;
    logic [INT_W-1:0]     ist;
    logic [INT_W-1:0]     imask;
    logic                 irq;
    logic [NPORT-1:0]     txpend;
    logic [NPORT-1:0][7:0] txdat;
    logic [NPORT-1:0][7:0] rxdat;
    logic [NPORT-1:0]     rxfull;
    logic [NPORT-1:0]     rxd_s1;
    logic [NPORT-1:0]     rxd_s2;
    logic [NPORT-1:0]     cts_s1;
    logic [NPORT-1:0]     cts_s2;
    logic                 pwr_s1;
    logic                 pwr_s2;
    logic                 alarm;
    logic                 quiet;
    logic [NPORT-1:0]     rts;
    logic [NPORT-1:0]     dtr;
  } sra_top_s;

  localparam sra_top_s TOP_RST = '{pend: CFG_RST, act: CFG_RST, rxd_s1: '1, rxd_s2: '1,
                                   alarm: 1'b1, dtr: '1, rts: '1, default: '0};

  logic [1:0]            rst_sync_ff;
  logic                  rst_n;
  sra_top_s              st_ff;
  sra_top_s              nxt_st;
  logic                  acc_rd;
  logic                  done;
  logic                  wr_en;
  logic                  accept_wr;
  logic                  cancel_wr;
  logic                  cfg_ok;
  logic [NPORT-1:0]      busy;
  logic [NPORT-1:0]      rx_vld;
  logic [NPORT-1:0]      rx_err;
  logic [NPORT-1:0][7:0] rx_data;
  logic [NPORT-1:0][15:0] div;
  logic [NPORT-1:0]      len8;
  logic [NPORT-1:0][1:0] par;
  logic [31:0]           rmux;
  logic                  rmiss;

  function automatic logic [15:0] div_of(input logic [2:0] idx);
    logic [15:0] d;
    d = 16'(CLK_HZ / BAUD_TBL[0]);
    for (int i = 0; i < NBAUD; i++) begin
      if (idx == 3'(i)) begin
        d = 16'(CLK_HZ / BAUD_TBL[i]);
      end
    end
    return d;
  endfunction : div_of

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Access phase answered one cycle later; effects land on the completing edge
  assign acc_rd    = psel_i && penable_i && !st_ff.pready;
  assign done      = psel_i && penable_i && st_ff.pready;
  assign wr_en     = done && pwrite_i;
  assign accept_wr = wr_en && (paddr_i == A_CFG_CMD) && pwdata_i[CMD_ACCEPT_BIT];
  assign cancel_wr = wr_en && (paddr_i == A_CFG_CMD) && pwdata_i[CMD_CANCEL_BIT];
  assign cfg_ok    = (st_ff.pend.baud < 3'(NBAUD)) && (st_ff.pend.parity != 2'h3) &&
                     (st_ff.pend.profile != 2'h3) &&
                     !(st_ff.pend.len8 && (st_ff.pend.parity != PAR_NONE)); // RQ10

  always_comb begin
    rmux  = 32'h0;
    rmiss = 1'b0;
    case (paddr_i)
      A_CFG_PEND:  rmux = {24'h0, st_ff.pend};
      A_CFG_CMD:   rmux = 32'h0;
      A_CFG_ACT:   rmux = {24'h0, st_ff.act};
      A_ALARM:     rmux = {30'h0, st_ff.sil, st_ff.urg};
      A_INT_STAT:  rmux = {25'h0, st_ff.ist};
      A_INT_MASK:  rmux = {25'h0, st_ff.imask};
      A_PORT_STAT: rmux = {22'h0, st_ff.rxfull, st_ff.alarm, st_ff.cts_s2, busy | st_ff.txpend};
      A_TXDATA0, A_TXDATA0 + A_PORT_STEP, A_TXDATA0 + 8'h2 * A_PORT_STEP: rmux = 32'h0;
      A_RXDATA0:                   rmux = {24'h0, st_ff.rxdat[0]};
      A_RXDATA0 + A_PORT_STEP:     rmux = {24'h0, st_ff.rxdat[1]};
      A_RXDATA0 + 8'h2 * A_PORT_STEP: rmux = {24'h0, st_ff.rxdat[2]};
      default:     rmiss = 1'b1;
    endcase
  end

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.rxd_s1 = rxd_i;
    nxt_st.rxd_s2 = st_ff.rxd_s1;
    nxt_st.cts_s1 = cts_i;
    nxt_st.cts_s2 = st_ff.cts_s1;
    nxt_st.pwr_s1 = power_switch_on_i;
    nxt_st.pwr_s2 = st_ff.pwr_s1;
    nxt_st.pready = acc_rd;
    if (acc_rd) begin
      nxt_st.prdata  = pwrite_i ? 32'h0 : rmux;
      nxt_st.pslverr = rmiss;
    end
    if (wr_en) begin
      case (paddr_i)
        A_CFG_PEND: nxt_st.pend  = sra_cfg_s'(pwdata_i[7:0]);
        A_ALARM:    {nxt_st.sil, nxt_st.urg} = pwdata_i[ALARM_SIL_BIT:ALARM_URG_BIT];
        A_INT_MASK: nxt_st.imask = pwdata_i[INT_W-1:0];
        A_INT_STAT: nxt_st.ist   = st_ff.ist & ~pwdata_i[INT_W-1:0];
        default:    nxt_st.imask = st_ff.imask;
      endcase
    end
    if (accept_wr) begin // RQ11
      if (cfg_ok) begin
        nxt_st.act = st_ff.pend;
      end else begin
        nxt_st.ist[INT_CFGREJ_BIT] = 1'b1; // RQ10
      end
    end else if (cancel_wr) begin
      nxt_st.pend = st_ff.act; // RQ11
    end
    for (int p = 0; p < NPORT; p++) begin
      if (st_ff.txpend[p] && busy[p]) begin
        nxt_st.txpend[p] = 1'b0;
      end
      // Writes to a busy transmitter are dropped; software polls busy first
      if (wr_en && paddr_i == A_TXDATA0 + 8'(p) * A_PORT_STEP && !st_ff.txpend[p] && !busy[p]) begin
        nxt_st.txpend[p] = 1'b1;
        nxt_st.txdat[p]  = pwdata_i[7:0];
      end
      if (done && !pwrite_i && paddr_i == A_RXDATA0 + 8'(p) * A_PORT_STEP) begin
        nxt_st.rxfull[p] = 1'b0;
      end
      if (rx_vld[p]) begin
        nxt_st.rxfull[p] = 1'b1;
        nxt_st.rxdat[p]  = rx_data[p];
        nxt_st.ist[INT_RXDONE_LSB + p] = 1'b1;
        nxt_st.ist[INT_RXERR_LSB + p]  = nxt_st.ist[INT_RXERR_LSB + p] | rx_err[p];
      end
    end
    nxt_st.dtr   = '1; // RQ5
    nxt_st.alarm = (st_ff.urg && !st_ff.sil) || !st_ff.pwr_s2; // RQ1 RQ2
    nxt_st.quiet = !nxt_st.alarm; // RQ3
    nxt_st.rts   = ~nxt_st.rxfull; // RQ4
    nxt_st.irq   = |(st_ff.ist & st_ff.imask);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= TOP_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    // Only the first port follows the accepted settings
    assign div[p]  = (p == 0) ? div_of(st_ff.act.baud) : div_of(CFG_FIXED.baud); // RQ6 RQ7
    assign len8[p] = (p == 0) ? st_ff.act.len8 : CFG_FIXED.len8; // RQ8
    assign par[p]  = (p == 0) ? st_ff.act.parity : CFG_FIXED.parity; // RQ9
    sra_uart_chan u_chan (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n),
      .div_i     (div[p]),
      .len8_i    (len8[p]),
      .par_i     (par[p]),
      .tx_go_i   (st_ff.txpend[p]),
      .tx_data_i (st_ff.txdat[p]),
      .cts_i     (st_ff.cts_s2[p]),
      .rxd_i     (st_ff.rxd_s2[p]),
      .txd_o     (txd_o[p]),
      .tx_busy_o (busy[p]),
      .rx_vld_o  (rx_vld[p]),
      .rx_err_o  (rx_err[p]),
      .rx_data_o (rx_data[p])
    ); // RQ4
  end

  assign pready_o            = st_ff.pready;
  assign pslverr_o           = st_ff.pslverr;
  assign prdata_o            = st_ff.prdata;
  assign irq_o               = st_ff.irq;
  assign rts_o               = st_ff.rts; // RQ4
  assign dtr_o               = st_ff.dtr; // RQ5
  assign port_one_profile_o  = st_ff.act.profile; // RQ6
  // Relay energised only when quiet, so a dead instrument reads as an alarm
  assign relay_coil_o        = st_ff.quiet; // RQ3
  assign contact_no_closed_o = st_ff.alarm; // RQ3
  assign contact_nc_closed_o = st_ff.quiet; // RQ3

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  chk_alarm_on:    assert property (st_ff.urg && !st_ff.sil |=> contact_no_closed_o) // RQ1
    else $error("urgent alarm not relayed");
  chk_silence:     assert property (st_ff.sil && st_ff.pwr_s2 |=> !contact_no_closed_o) // RQ1
    else $error("silenced alarm still relayed");
  chk_power_off:   assert property (!power_switch_on_i ##1 !power_switch_on_i ##1
                                    !power_switch_on_i |=> contact_no_closed_o) // RQ2
    else $error("power off not shown as alarm");
  chk_changeover:  assert property (contact_no_closed_o != contact_nc_closed_o) // RQ3
    else $error("contacts not complementary");
  chk_dtr_high:    assert property (dtr_o == 3'h7) // RQ5
    else $error("dtr not held high");
  chk_fixed_ports: assert property (len8[2:1] == 2'h3 && par[1] == PAR_NONE &&
                                    div[2] == div_of(BAUD_IDX_9600)) // RQ6
    else $error("fixed ports left their profile");
  chk_reject:      assert property (accept_wr && st_ff.pend.len8 && st_ff.pend.parity != PAR_NONE
                                    |=> st_ff.act == $past(st_ff.act) &&
                                    st_ff.ist[INT_CFGREJ_BIT]) // RQ10
    else $error("illegal setting accepted");
  chk_cancel:      assert property (cancel_wr && !accept_wr |=> st_ff.pend == $past(st_ff.act)
                                    && st_ff.act == $past(st_ff.act)) // RQ11
    else $error("cancel did not restore settings");
  chk_pready_one:  assert property (acc_rd |=> pready_o ##1 !pready_o)
    else $error("apb answer not one cycle");

  cov_accept:      cover property (accept_wr && cfg_ok);
  cov_reject:      cover property (accept_wr && !cfg_ok);
  cov_alarm:       cover property ($rose(contact_no_closed_o));

endmodule : sra_top
`default_nettype wire

// file: sra_pkg.sv
// Constants and types for the serial port and remote alarm block
// Operation
// RQ1: Remote alarm active for medium or high urgency alarm, inactive while silenced.
// RQ2: Remote alarm active whenever the main power switch is off.
// RQ3: Alarm drives a changeover contact: common, normally-open and normally-closed.
// RQ4: Ports are terminal side: send on txd, receive on rxd, drive rts, sample cts.
// RQ5: Data-terminal-ready held permanently high on every port.
// RQ6: Three ports; only the first takes a profile, others fixed to data link.
// RQ7: Configurable port runs at 1200 to 38400 baud by setting.
// RQ8: Character length of seven or eight data bits by setting.
// RQ9: Parity none, even or odd by setting.
// RQ10: Eight data bits with even or odd parity is rejected.
// RQ11: Pending settings apply only on accept; cancel discards and keeps old settings.
// RQ12: Attached printer and cable converter use the same baud, parity and length.
// RQ13: Frame is low start, data LSB first, optional parity, one high stop.
package sra_pkg;

  localparam int unsigned NPORT    = 3;
  localparam int unsigned NBAUD    = 6;
  localparam int unsigned CLK_HZ   = 50_000_000;
  localparam int unsigned BAUD_TBL [NBAUD] = '{1200, 2400, 4800, 9600, 19200, 38400};

  // Register byte offsets
  localparam logic [7:0] A_CFG_PEND  = 8'h00;
  localparam logic [7:0] A_CFG_CMD   = 8'h04;
  localparam logic [7:0] A_CFG_ACT   = 8'h08;
  localparam logic [7:0] A_ALARM     = 8'h0c;
  localparam logic [7:0] A_INT_STAT  = 8'h10;
  localparam logic [7:0] A_INT_MASK  = 8'h14;
  localparam logic [7:0] A_PORT_STAT = 8'h18;
  localparam logic [7:0] A_TXDATA0   = 8'h20;
  localparam logic [7:0] A_RXDATA0   = 8'h30;
  localparam logic [7:0] A_PORT_STEP = 8'h04;

  // Field positions
  localparam int unsigned CMD_ACCEPT_BIT = 0;
  localparam int unsigned CMD_CANCEL_BIT = 1;
  localparam int unsigned ALARM_URG_BIT  = 0;
  localparam int unsigned ALARM_SIL_BIT  = 1;
  localparam int unsigned INT_RXDONE_LSB = 0;
  localparam int unsigned INT_RXERR_LSB  = 3;
  localparam int unsigned INT_CFGREJ_BIT = 6;
  localparam int unsigned INT_W          = 7;
  localparam int unsigned PST_BUSY_LSB   = 0;
  localparam int unsigned PST_CTS_LSB    = 3;
  localparam int unsigned PST_ALARM_BIT  = 6;
  localparam int unsigned PST_RXFULL_LSB = 7;

  // Parity and profile codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PROF_HOST_DATA_LINK       = 2'h0;
  localparam logic [1:0] PROF_PRINTER              = 2'h1;
  localparam logic [1:0] PROF_THIRD_PARTY_MONITOR  = 2'h2;

  // Configuration word: [7:6] parity, [5] len8, [4:2] baud index, [1:0] profile
  typedef struct packed {
    logic [1:0] parity;
    logic       len8;
    logic [2:0] baud;
    logic [1:0] profile;
  } sra_cfg_s;

  localparam logic [2:0] BAUD_IDX_9600 = 3'h3;
  localparam sra_cfg_s CFG_RST   = '{parity: PAR_NONE, len8: 1'b1, baud: BAUD_IDX_9600,
                                     profile: PROF_HOST_DATA_LINK};
  localparam sra_cfg_s CFG_FIXED = CFG_RST;

  typedef enum logic [2:0] {BIT_IDLE, BIT_START, BIT_DATA, BIT_PAR, BIT_STOP} sra_bit_e;

endpackage : sra_pkg

// file: sra_uart_chan.sv
// One serial channel: transmitter and receiver with runtime framing
`timescale 1ns/100ps
`default_nettype none
module sra_uart_chan (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] div_i,
  input  wire logic        len8_i,
  input  wire logic [1:0]  par_i,
  input  wire logic        tx_go_i,
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        cts_i,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             tx_busy_o,
  output logic             rx_vld_o,
  output logic             rx_err_o,
  output logic [7:0]       rx_data_o
);
  import sra_pkg::*;

  typedef struct packed {
    sra_bit_e    tst;
    logic [15:0] tcnt;
    logic [2:0]  tbit;
    logic [7:0]  tsh;
    logic        tpar;
    logic        txd;
    sra_bit_e    rst;
    logic [15:0] rcnt;
    logic [2:0]  rbit;
    logic [7:0]  rsh;
    logic        rpar;
    logic        rvld;
    logic        rerr;
    logic [7:0]  rdata;
  } sra_chan_s;

  localparam sra_chan_s CHAN_RST = '{tst: BIT_IDLE, rst: BIT_IDLE, txd: 1'b1, default: '0};

  sra_chan_s st_ff;
  sra_chan_s nxt_st;
  logic [2:0] last;
  logic [7:0] tdat;

  assign last = len8_i ? 3'h7 : 3'h6;
  assign tdat = len8_i ? tx_data_i : {1'b0, tx_data_i[6:0]};

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.rvld = 1'b0;
    nxt_st.rerr = 1'b0;
    case (st_ff.tst)
      BIT_IDLE: begin
        nxt_st.txd = 1'b1;
        if (tx_go_i && cts_i) begin // RQ4
          nxt_st.tst  = BIT_START;
          nxt_st.tsh  = tdat;
          nxt_st.tpar = (par_i == PAR_ODD) ^ (^tdat); // RQ9
          nxt_st.tcnt = div_i - 16'h1; // RQ7
          nxt_st.txd  = 1'b0; // RQ13
        end
      end
      default: begin
        if (st_ff.tcnt != 16'h0) begin
          nxt_st.tcnt = st_ff.tcnt - 16'h1;
        end else begin
          nxt_st.tcnt = div_i - 16'h1;
          case (st_ff.tst)
            BIT_START: begin
              nxt_st.tst  = BIT_DATA;
              nxt_st.tbit = 3'h0;
              nxt_st.txd  = st_ff.tsh[0]; // RQ13
              nxt_st.tsh  = {1'b0, st_ff.tsh[7:1]};
            end
            BIT_DATA: begin
              if (st_ff.tbit == last) begin // RQ8
                nxt_st.tst = (par_i == PAR_NONE) ? BIT_STOP : BIT_PAR;
                nxt_st.txd = (par_i == PAR_NONE) ? 1'b1 : st_ff.tpar;
              end else begin
                nxt_st.tbit = st_ff.tbit + 3'h1;
                nxt_st.txd  = st_ff.tsh[0];
                nxt_st.tsh  = {1'b0, st_ff.tsh[7:1]};
              end
            end
            BIT_PAR: begin
              nxt_st.tst = BIT_STOP;
              nxt_st.txd = 1'b1; // RQ13
            end
            default: begin
              nxt_st.tst = BIT_IDLE;
              nxt_st.txd = 1'b1;
            end
          endcase
        end
      end
    endcase
    case (st_ff.rst)
      BIT_IDLE: begin
        if (!rxd_i) begin
          nxt_st.rst  = BIT_START;
          nxt_st.rcnt = {1'b0, div_i[15:1]};
        end
      end
      default: begin
        if (st_ff.rcnt != 16'h0) begin
          nxt_st.rcnt = st_ff.rcnt - 16'h1;
        end else begin
          nxt_st.rcnt = div_i - 16'h1;
          case (st_ff.rst)
            BIT_START: begin
              // Glitch shorter than half a bit is dropped
              nxt_st.rst  = rxd_i ? BIT_IDLE : BIT_DATA;
              nxt_st.rbit = 3'h0;
              nxt_st.rpar = 1'b0;
            end
            BIT_DATA: begin
              nxt_st.rsh  = {rxd_i, st_ff.rsh[7:1]}; // RQ13
              nxt_st.rpar = st_ff.rpar ^ rxd_i;
              if (st_ff.rbit == last) begin
                nxt_st.rst = (par_i == PAR_NONE) ? BIT_STOP : BIT_PAR;
              end else begin
                nxt_st.rbit = st_ff.rbit + 3'h1;
              end
            end
            BIT_PAR: begin
              nxt_st.rpar = st_ff.rpar ^ rxd_i;
              nxt_st.rst  = BIT_STOP;
            end
            default: begin
              nxt_st.rst   = BIT_IDLE;
              nxt_st.rvld  = 1'b1;
              nxt_st.rdata = len8_i ? st_ff.rsh : {1'b0, st_ff.rsh[7:1]};
              nxt_st.rerr  = !rxd_i ||
                             ((par_i != PAR_NONE) && (st_ff.rpar != (par_i == PAR_ODD))); // RQ9
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= CHAN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign txd_o     = st_ff.txd;
  assign tx_busy_o = (st_ff.tst != BIT_IDLE);
  assign rx_vld_o  = st_ff.rvld;
  assign rx_err_o  = st_ff.rerr;
  assign rx_data_o = st_ff.rdata;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_start_low:  assert property ($rose(tx_busy_o) |-> !txd_o) // RQ13
    else $error("start bit not low");
  chk_cts_gate:   assert property (!cts_i && !tx_busy_o |=> !tx_busy_o) // RQ4
    else $error("frame started without cts");
  chk_par_only:   assert property (st_ff.tst == BIT_PAR |-> par_i != PAR_NONE) // RQ9
    else $error("parity bit sent with parity off");
  chk_stop_high:  assert property (st_ff.tst == BIT_STOP |-> txd_o) // RQ13
    else $error("stop bit not high");
  cov_rx_frame:   cover property (rx_vld_o && !rx_err_o);

endmodule : sra_uart_chan
`default_nettype wire

// file: sra_far_end.sv
// Far-end serial device model: frame decoder on txd, frame sender on rxd
`timescale 1ns/100ps
`default_nettype none
module sra_far_end (
  input  wire logic        clk_i,
  input  wire logic        txd_i,
  input  wire logic        hold_i,
  input  wire logic [15:0] div_i,
  input  wire logic        len8_i,
  input  wire logic [1:0]  par_i,
  output logic             rxd_o,
  output logic             cts_o,
  output logic             got_stb_o,
  output logic             got_ok_o,
  output logic [7:0]       got_o
);
  import sra_pkg::*;
  logic p;
  // Same baud, length and parity as the port under test
  assign cts_o = !hold_i;
  initial begin
    rxd_o = 1'b1;
    got_stb_o = 1'b0;
  end
  always begin
    @(negedge txd_i);
    repeat (div_i / 2) @(posedge clk_i);
    got_ok_o = (txd_i === 1'b0);
    got_o = 8'h00;
    for (int k = 0; k < (len8_i ? 8 : 7); k++) begin
      repeat (div_i) @(posedge clk_i);
      got_o[k] = txd_i;
    end
    p = ^got_o ^ (par_i == PAR_ODD);
    if (par_i != PAR_NONE) begin
      repeat (div_i) @(posedge clk_i);
      got_ok_o &= (txd_i === p);
    end
    repeat (div_i) @(posedge clk_i);
    got_ok_o &= (txd_i === 1'b1);
    got_stb_o = 1'b1;
    @(posedge clk_i);
    got_stb_o = 1'b0;
  end
  // Parity can be spoiled on request to provoke a receive error
  task automatic send(input logic [7:0] d, input logic bad);
    logic [7:0] m;
    m = len8_i ? d : {1'b0, d[6:0]};
    rxd_o <= 1'b0;
    repeat (div_i) @(posedge clk_i);
    for (int k = 0; k < (len8_i ? 8 : 7); k++) begin
      rxd_o <= m[k];
      repeat (div_i) @(posedge clk_i);
    end
    if (par_i != PAR_NONE) begin
      rxd_o <= ^m ^ (par_i == PAR_ODD) ^ bad;
      repeat (div_i) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
    repeat (div_i) @(posedge clk_i);
  endtask : send
endmodule : sra_far_end
`default_nettype wire

// file: test_serial_port_and_remote_alarm.sv
// Self-checking bench for the serial ports and remote alarm block
`timescale 1ns/100ps
`default_nettype none
module test_serial_port_and_remote_alarm;
  import sra_pkg::*;
  // Low clock figure shortens every bit time
  localparam int unsigned HZ = 1_000_000;
  localparam int LIMIT = 40000;
  logic clk_i = 0, arst_n_i = 0, psel = 0, pen = 0, pwr = 0, pon = 1;
  logic [7:0]  pa = 0;
  logic [31:0] pwd = 0, seed = 32'ha67ea07c;
  logic [2:0]  hold = 0, len8 = 3'b111;
  logic [1:0]  p;
  logic [2:0][15:0] div = {3{16'(HZ / 9600)}};
  logic [2:0][1:0]  par = 0;
  wire  [2:0]  rxd, cts, txd, rts, dtr, stb, ok;
  wire  [2:0][7:0] got;
  wire  [31:0] prd;
  wire  [1:0]  prof;
  wire         rdy, err, irq, coil, no_c, nc_c;
  logic [32:0] exp_rd [$];
  logic [10:0] exp_tx [$];
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  always #10 clk_i = ~clk_i;
  sra_top #(.CLK_HZ(HZ)) i_sra_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pready_o(rdy),
    .pslverr_o(err), .prdata_o(prd), .irq_o(irq), .rxd_i(rxd), .cts_i(cts), .txd_o(txd),
    .rts_o(rts), .dtr_o(dtr), .port_one_profile_o(prof), .power_switch_on_i(pon),
    .relay_coil_o(coil), .contact_no_closed_o(no_c), .contact_nc_closed_o(nc_c));
  for (genvar g = 0; g < 3; g++) begin : gp
    sra_far_end i_sra_far_end (.clk_i(clk_i), .txd_i(txd[g]), .hold_i(hold[g]),
      .div_i(div[g]), .len8_i(len8[g]), .par_i(par[g]), .rxd_o(rxd[g]), .cts_o(cts[g]),
      .got_stb_o(stb[g]), .got_ok_o(ok[g]), .got_o(got[g]));
    always @(posedge stb[g]) cmp("frame", 33'(exp_tx.pop_front()), {2'(g), ok[g], got[g]});
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic test_done;
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do @(posedge clk_i); while (rdy !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd_chk
  // Every read completion is judged against the oldest note
  always @(posedge clk_i) begin
    if (psel && pen && rdy === 1'b1 && !pwr) begin
      logic [32:0] e;
      e = exp_rd.pop_front();
      cmp("pslverr", e[32], err);
      if (!e[32]) cmp("prdata", e[31:0], prd);
    end
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    cmp("dtr", 3'b111, dtr);
    rd_chk(8'h40, {1'b1, 32'h0});
    rd_chk(A_CFG_ACT, 32'h2c);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, A_ALARM, {30'h0, 2'(i)});
      pon <= i[2];
      repeat (6) @(posedge clk_i);
      p = {1'b0, (i[0] & !i[1]) | !i[2]};
      cmp("contacts", {!p[0], p[0], !p[0]}, {coil, no_c, nc_c});
    end
    apb(1'b1, A_CFG_PEND, 32'h55);
    apb(1'b1, A_CFG_CMD, 32'h2);
    rd_chk(A_CFG_ACT, 32'h2c);
    rd_chk(A_CFG_PEND, 32'h2c);
    apb(1'b1, A_CFG_PEND, 32'h55);
    apb(1'b1, A_CFG_CMD, 32'h1);
    apb(1'b1, A_CFG_ACT, 32'h0);
    rd_chk(A_CFG_ACT, 32'h55);
    cmp("profile", PROF_PRINTER, prof);
    apb(1'b1, A_CFG_PEND, 32'h6c);
    apb(1'b1, A_CFG_CMD, 32'h1);
    rd_chk(A_CFG_ACT, 32'h55);
    rd_chk(A_INT_STAT, 32'h40);
    cmp("irq_masked", 1'b0, irq);
    apb(1'b1, A_INT_MASK, 32'h40);
    @(posedge clk_i);
    cmp("irq", 1'b1, irq);
    apb(1'b1, A_INT_STAT, 32'h40);
    @(posedge clk_i);
    cmp("irq_clr", 1'b0, irq);
    // Every baud index, every parity; first frame stalled by cts
    for (int i = 0; i < 6; i++) begin
      p = 2'(i % 3);
      hold[0] <= (i == 0);
      apb(1'b1, A_CFG_PEND, {24'h0, p, p == PAR_NONE, 3'(i), 2'h0});
      apb(1'b1, A_CFG_CMD, 32'h1);
      div[0] = 16'(HZ / BAUD_TBL[i]);
      par[0] = p;
      len8[0] = (p == PAR_NONE);
      seed = xs(seed);
      exp_tx.push_back({2'd0, 1'b1, seed[7:0] & (len8[0] ? 8'hff : 8'h7f)});
      apb(1'b1, A_TXDATA0, {24'h0, seed[7:0]});
      if (i == 0) begin
        repeat (100) @(posedge clk_i);
        cmp("txd_held", 1'b1, txd[0]);
        hold[0] <= 1'b0;
      end
      while (exp_tx.size() != 0) @(posedge clk_i);
      repeat (div[0]) @(posedge clk_i);
    end
    exp_tx.push_back({2'd1, 1'b1, 8'h35});
    exp_tx.push_back({2'd2, 1'b1, 8'h6a});
    apb(1'b1, A_TXDATA0 + A_PORT_STEP, 32'h35);
    apb(1'b1, A_TXDATA0 + 2 * A_PORT_STEP, 32'h6a);
    while (exp_tx.size() != 0) @(posedge clk_i);
    seed = xs(seed);
    gp[0].i_sra_far_end.send(seed[7:0], 1'b0);
    while (rts[0] !== 1'b0) @(posedge clk_i);
    rd_chk(A_INT_STAT, 32'h1);
    rd_chk(A_RXDATA0, {25'h0, seed[6:0]});
    cmp("rts", 1'b1, rts[0]);
    apb(1'b1, A_INT_STAT, 32'h1);
    gp[0].i_sra_far_end.send(seed[15:8], 1'b1);
    while (rts[0] !== 1'b0) @(posedge clk_i);
    rd_chk(A_INT_STAT, 32'h9);
    rd_chk(A_PORT_STAT, 32'hb8);
    test_done();
  end
endmodule : test_serial_port_and_remote_alarm
`default_nettype wire
